// ---- design/htp_pkg.sv ----
// Types shared by the hit pulse generator
// Register map and timing live in htp_regs.svh
package htp_pkg;

    typedef struct packed {
        logic [9:0] threshold;
        logic [1:0] hysteresis;
        logic [2:0] inputBiasSelect;
    } htp_cfg_t;

    typedef struct packed {
        logic [7:0] arrivalTime;
        logic [7:0] pulseWidth;
        logic [7:0] calibration;
    } htp_words_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [31:0] writedata;
    } htp_av_req_t;

    typedef enum logic [0:0] {
        HTP_IDLE,
        HTP_MEASURE
    } htp_state_t;

endpackage

// ---- design/htp_regs.svh ----
// Offsets, field positions, reset values and timing of the hit pulse generator
// Included by the package user; definitions only
`ifndef HTP_REGS_SVH
`define HTP_REGS_SVH

// Register byte offsets
`define HTP_OFS_CTRL 8'h00
`define HTP_OFS_CONFIG 8'h04
`define HTP_OFS_STATUS 8'h08
`define HTP_OFS_ARRIVAL 8'h0c
`define HTP_OFS_WIDTH 8'h10
`define HTP_OFS_CAL 8'h14

// Control fields
`define HTP_CTRL_ENABLE 0
`define HTP_CTRL_SOFT_RESET 1
`define HTP_CTRL_TEST_MODE 2
`define HTP_CTRL_TEST_FIRE 3

// Configuration fields
`define HTP_CFG_THR_LSB 0
`define HTP_CFG_THR_MSB 9
`define HTP_CFG_HYS_LSB 10
`define HTP_CFG_HYS_MSB 11
`define HTP_CFG_BIAS_LSB 12
`define HTP_CFG_BIAS_MSB 14

// Status fields
`define HTP_STAT_BUSY 0
`define HTP_STAT_VALID 1
`define HTP_STAT_MISSED 2

// Reset values
`define HTP_ENABLE_RST 1'b1
`define HTP_THR_RST 10'h000
`define HTP_HYS_RST 2'h0
`define HTP_BIAS_RST 3'h0

// Accepted input bias codes
`define HTP_BIAS_A 3'h0
`define HTP_BIAS_B 3'h1
`define HTP_BIAS_C 3'h3
`define HTP_BIAS_D 3'h7

// Timing
`define HTP_CLK_PERIOD_PS 4000
`define HTP_WINDOW_PS 6250
`define HTP_TEST_PULSE_PS 12500
`define HTP_FIRST_GAP_CYC 4'h4
`define HTP_STAMP_MAX 8'hff

`endif

// ---- design/htp_sync.sv ----
// Three-stage synchroniser for pins from outside the mclk domain
// Assumes mclk free-running; output follows once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module htp_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Pins and clean levels
    input wire logic [WIDTH-1:0] din,
    output var logic [WIDTH-1:0] dout
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic ff1;
            logic ff2;
            logic ff3;
            always_ff @(posedge mclk) begin
                if (!rstn) begin
                    ff1 <= 1'b0;
                    ff2 <= 1'b0;
                    ff3 <= 1'b0;
                    dout[i] <= 1'b0;
                end else begin
                    ff1 <= din[i];
                    ff2 <= ff1;
                    ff3 <= ff2;
                    if (ff2 == ff3) begin
                        dout[i] <= ff3;
                    end
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// ---- design/htp_top.sv ----
// Hit pulse generator, stamp capture and encoders of a pixel time digitizer
// Assumes hit and gated clock pins asynchronous to mclk; Avalon-MM slave
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "htp_regs.svh"
module htp_top
    import htp_pkg::*;
#(
    parameter int STAMP_STEP_PS = `HTP_CLK_PERIOD_PS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Register bus
    input wire htp_av_req_t avReq,
    output var logic [31:0] avReaddata,
    output var logic avWaitrequest,
    // Analog front end pins
    input wire logic hitIn,
    input wire logic gatedClkIn,
    // Delay line drive
    output var logic start,
    output var logic arrivalSampleClock,
    output var logic widthSampleClock,
    // Front end settings and data words
    output var htp_cfg_t cfg,
    output var htp_words_t words
);

    localparam int WINDOW_CYC_RAW = `HTP_WINDOW_PS / `HTP_CLK_PERIOD_PS;
    localparam int WINDOW_CYC = (WINDOW_CYC_RAW < 1) ? 1 : WINDOW_CYC_RAW;
    localparam int TEST_CYC_RAW = `HTP_TEST_PULSE_PS / `HTP_CLK_PERIOD_PS;
    localparam int TEST_CYC = (TEST_CYC_RAW < 1) ? 1 : TEST_CYC_RAW;
    localparam logic [3:0] WINDOW_LIM = 4'(WINDOW_CYC);
    localparam logic [3:0] TEST_LIM = 4'(TEST_CYC);

    // Bias codes other than the four legal ones are refused
    function automatic logic biasLegal(input logic [2:0] code);
        biasLegal = (code == `HTP_BIAS_A) || (code == `HTP_BIAS_B) ||
            (code == `HTP_BIAS_C) || (code == `HTP_BIAS_D);
    endfunction

    // Control and status state
    logic enable;
    logic testMode;
    logic dataValid;
    logic missed;
    htp_state_t state;

    // Synchronised pins
    logic [1:0] pinLevel;
    htp_sync #(.WIDTH(2)) htp_sync_i (
        .mclk(mclk),
        .rstn(rstn),
        .din({gatedClkIn, hitIn}),
        .dout(pinLevel)
    );

    // Bus decode
    wire busReq = avReq.read | avReq.write;
    wire accept = busReq & ~avWaitrequest;
    wire wrEn = accept & avReq.write;
    wire selCtrl = avReq.address == `HTP_OFS_CTRL;
    wire selCfg = avReq.address == `HTP_OFS_CONFIG;
    wire selStat = avReq.address == `HTP_OFS_STATUS;
    wire selArr = avReq.address == `HTP_OFS_ARRIVAL;
    wire selWid = avReq.address == `HTP_OFS_WIDTH;
    wire selCal = avReq.address == `HTP_OFS_CAL;
    wire wrCtrl = wrEn & selCtrl;
    wire wrCfg = wrEn & selCfg;
    wire wrStat = wrEn & selStat;
    wire softReset = wrCtrl & avReq.writedata[`HTP_CTRL_SOFT_RESET];
    wire testFire = wrCtrl & avReq.writedata[`HTP_CTRL_TEST_FIRE];
    wire [2:0] biasWr = avReq.writedata[`HTP_CFG_BIAS_MSB:`HTP_CFG_BIAS_LSB];
    wire busy = state == HTP_MEASURE;

    logic [31:0] next_readdata;
    always_comb begin
        next_readdata = 32'h0000_0000;
        if (selCtrl) begin
            next_readdata[`HTP_CTRL_ENABLE] = enable;
            next_readdata[`HTP_CTRL_TEST_MODE] = testMode;
        end else if (selCfg) begin
            next_readdata[14:0] = {cfg.inputBiasSelect, cfg.hysteresis,
                cfg.threshold};
        end else if (selStat) begin
            next_readdata[`HTP_STAT_BUSY] = busy;
            next_readdata[`HTP_STAT_VALID] = dataValid;
            next_readdata[`HTP_STAT_MISSED] = missed;
        end else if (selArr) begin
            next_readdata[7:0] = words.arrivalTime;
        end else if (selWid) begin
            next_readdata[7:0] = words.pulseWidth;
        end else if (selCal) begin
            next_readdata[7:0] = words.calibration;
        end
    end

    // One wait cycle, then answer for one cycle
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            avWaitrequest <= 1'b1;
            avReaddata <= 32'h0000_0000;
        end else begin
            avWaitrequest <= ~(busReq & avWaitrequest);
            if (busReq & avWaitrequest) begin
                avReaddata <= avReq.read ? next_readdata : 32'h0000_0000;
            end
        end
    end

    // Control and configuration registers
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            enable <= `HTP_ENABLE_RST;
            testMode <= 1'b0;
            cfg.threshold <= `HTP_THR_RST;
            cfg.hysteresis <= `HTP_HYS_RST;
            cfg.inputBiasSelect <= `HTP_BIAS_RST;
        end else begin
            if (wrCtrl) begin
                enable <= avReq.writedata[`HTP_CTRL_ENABLE];
                testMode <= avReq.writedata[`HTP_CTRL_TEST_MODE];
            end
            if (wrCfg) begin
                cfg.threshold <= avReq.writedata[9:0];
                cfg.hysteresis <= avReq.writedata[11:10];
                if (biasLegal(biasWr)) begin
                    cfg.inputBiasSelect <= biasWr;
                end
            end
        end
    end

    // Internal test pulse in place of the comparator
    logic [3:0] testCnt;
    logic testPulse;
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            testCnt <= 4'h0;
            testPulse <= 1'b0;
        end else if (testFire & ~testPulse) begin
            testCnt <= 4'h1;
            testPulse <= 1'b1;
        end else if (testPulse) begin
            testCnt <= testCnt + 4'h1;
            testPulse <= testCnt < TEST_LIM;
        end
    end

    // Edge detection on clean levels
    wire hitLevel = testMode ? testPulse : pinLevel[0];
    wire gclkLevel = pinLevel[1];
    logic hitPrev;
    logic gclkPrev;
    logic [3:0] gapCnt;
    wire hitRise = hitLevel & ~hitPrev;
    wire hitFall = ~hitLevel & hitPrev;
    wire gRise = gclkLevel & ~gclkPrev;
    wire gFall = ~gclkLevel & gclkPrev;
    wire gFirstRise = gRise & (gapCnt >= `HTP_FIRST_GAP_CYC);
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            hitPrev <= 1'b0;
            gclkPrev <= 1'b0;
            gapCnt <= 4'h0;
        end else begin
            hitPrev <= hitLevel;
            gclkPrev <= gclkLevel;
            if (gRise) begin
                gapCnt <= 4'h0;
            end else if (gapCnt != 4'hf) begin
                gapCnt <= gapCnt + 4'h1;
            end
        end
    end

    // Hit waiting for the window to close at the first clock rise
    logic pending;
    logic pendFell;
    logic [3:0] hitAge;
    wire armed = enable & ~busy;
    wire takeNow = pending & ~hitRise;
    wire startNow = armed & gFirstRise & (takeNow | hitRise);
    wire expire = pending & ~gFirstRise & ((hitAge + 4'h1) >= WINDOW_LIM);
    wire ignoredHit = hitRise & (busy | ~enable);
    always_ff @(posedge mclk) begin
        if (!rstn || softReset || !enable) begin
            pending <= 1'b0;
            pendFell <= 1'b0;
            hitAge <= 4'h0;
        end else if (startNow || expire) begin
            pending <= 1'b0;
            pendFell <= 1'b0;
            hitAge <= 4'h0;
        end else if (hitRise && !busy) begin
            pending <= 1'b1;
            pendFell <= 1'b0;
            hitAge <= 4'h0;
        end else if (pending) begin
            hitAge <= hitAge + 4'h1;
            pendFell <= pendFell | hitFall;
        end
    end

    // Measurement sequence
    logic clkEn;
    logic [1:0] fallCnt;
    logic [1:0] arrRiseCnt;
    logic widthDone;
    logic [7:0] stampCnt;
    logic [7:0] stampArr;
    logic [7:0] stampCal;
    logic [7:0] stampEnd;
    wire fellBefore = hitRise ? 1'b0 : (pendFell | hitFall);
    wire secondFall = clkEn & gFall & (fallCnt == 2'h1);
    wire next_clkEn = startNow | (clkEn & ~secondFall);
    wire next_arrClk = next_clkEn & gclkLevel & enable;
    wire arrEdge = next_arrClk & ~arrivalSampleClock;
    wire next_widClk = enable & ((startNow & fellBefore) |
        (busy & hitFall & ~widthDone));
    wire arrDone = arrRiseCnt == 2'h2;
    wire finish = busy & arrDone & widthDone;
    wire [7:0] stampNow = (stampCnt == `HTP_STAMP_MAX) ? stampCnt :
        stampCnt + 8'h01;
    wire [7:0] stampStart = hitRise ? 8'h01 : {4'h0, hitAge} + 8'h02;

    always_ff @(posedge mclk) begin
        if (!rstn || softReset || !enable) begin
            state <= HTP_IDLE;
            start <= 1'b0;
            clkEn <= 1'b0;
            arrivalSampleClock <= 1'b0;
            widthSampleClock <= 1'b0;
        end else begin
            arrivalSampleClock <= next_arrClk;
            widthSampleClock <= next_widClk;
            clkEn <= next_clkEn;
            if (startNow) begin
                state <= HTP_MEASURE;
                start <= 1'b1;
            end else if (finish) begin
                state <= HTP_IDLE;
                start <= 1'b0;
            end
        end
    end

    // Stamp capture, the counter stands in for the delay line
    always_ff @(posedge mclk) begin
        if (!rstn || softReset || !enable) begin
            fallCnt <= 2'h0;
            arrRiseCnt <= 2'h0;
            widthDone <= 1'b0;
            stampCnt <= 8'h00;
            stampArr <= 8'h00;
            stampCal <= 8'h00;
            stampEnd <= 8'h00;
        end else if (startNow) begin
            fallCnt <= 2'h0;
            arrRiseCnt <= {1'b0, arrEdge};
            widthDone <= next_widClk;
            stampCnt <= stampStart;
            stampArr <= stampStart;
            stampEnd <= stampStart;
        end else if (busy) begin
            stampCnt <= stampNow;
            if (clkEn && gFall && fallCnt != 2'h2) begin
                fallCnt <= fallCnt + 2'h1;
            end
            if (arrEdge && !arrDone) begin
                arrRiseCnt <= arrRiseCnt + 2'h1;
                if (arrRiseCnt == 2'h0) begin
                    stampArr <= stampNow;
                end else begin
                    stampCal <= stampNow;
                end
            end
            if (next_widClk) begin
                widthDone <= 1'b1;
                stampEnd <= stampNow;
            end
        end
    end

    // Encoders and sticky status
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            words <= '0;
            dataValid <= 1'b0;
            missed <= 1'b0;
        end else begin
            if (finish) begin
                words.arrivalTime <= stampArr;
                words.pulseWidth <= stampEnd;
                words.calibration <= stampCal - stampArr;
            end
            if (finish) begin
                dataValid <= 1'b1;
            end else if (wrStat && avReq.writedata[`HTP_STAT_VALID]) begin
                dataValid <= 1'b0;
            end
            if (expire || ignoredHit) begin
                missed <= 1'b1;
            end else if (wrStat && avReq.writedata[`HTP_STAT_MISSED]) begin
                missed <= 1'b0;
            end
        end
    end

    // Checks
    a_start_needs_window: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(start) |-> $past(gFirstRise) && $past(enable))
        else $error("start rose without a window clock edge");
    a_start_drop_done: assert property (@(posedge mclk) disable iff (!rstn)
        $fell(start) && $past(enable) && !$past(softReset)
        |-> $past(arrDone) && $past(widthDone))
        else $error("start dropped before both stamps");
    a_arr_clk_gated: assert property (@(posedge mclk) disable iff (!rstn)
        arrivalSampleClock |-> $past(gclkLevel) && (clkEn || $past(clkEn)))
        else $error("arrival clock without enable");
    a_clken_after_start: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(start) |-> clkEn)
        else $error("clock enable not set with start");
    a_clken_clear: assert property (@(posedge mclk) disable iff (!rstn)
        clkEn && secondFall && !startNow |=> !clkEn)
        else $error("clock enable kept past second fall");
    a_quiet_idle: assert property (@(posedge mclk) disable iff (!rstn)
        !busy && !startNow && !$past(busy) |=> !arrivalSampleClock
        && !widthSampleClock && !start)
        else $error("outputs active without a hit");
    a_disable_hold: assert property (@(posedge mclk) disable iff (!rstn)
        !enable |=> !start && !arrivalSampleClock && !widthSampleClock)
        else $error("outputs active while disabled");
    a_busy_no_restart: assert property (@(posedge mclk) disable iff (!rstn)
        busy && !finish && enable && !softReset
        |=> start && !$rose(start))
        else $error("measurement restarted while busy");
    a_width_once: assert property (@(posedge mclk) disable iff (!rstn)
        widthSampleClock |=> !widthSampleClock)
        else $error("width clock held longer than a cycle");
    a_bias_legal: assert property (@(posedge mclk) disable iff (!rstn)
        biasLegal(cfg.inputBiasSelect))
        else $error("illegal input bias code stored");
    a_test_width: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(testPulse) |-> testPulse [*3] ##1 !testPulse)
        else $error("test pulse width wrong");
    a_valid_sets: assert property (@(posedge mclk) disable iff (!rstn)
        finish |=> dataValid && words.arrivalTime == $past(stampArr))
        else $error("encoded words not latched");

endmodule
`default_nettype wire

// ---- tb/hit_time_pulse_generator_tb.sv ----
// Self-checking bench of the hit pulse generator
// Assumes htp_pkg compiled first and htp_regs.svh on the include path
`timescale 1ns/10ps
`default_nettype none
`include "htp_regs.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin nFail++; \
$display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module hit_time_pulse_generator_tb
    import htp_pkg::*;
;
    localparam int FRAME = 64;
    localparam int HI = 4;
    localparam int LO = 4;
    logic mclk, rstn, avWaitrequest, hitIn, gatedClkIn, armHit;
    logic start, arrivalSampleClock, widthSampleClock;
    logic pStart, pArr, pWid;
    htp_av_req_t avReq;
    logic [31:0] avReaddata, seed, rdExp;
    htp_cfg_t cfg, cfgExp;
    htp_words_t words;
    logic [3:0] hitOfs;
    logic [7:0] hitLen, phase;
    logic [31:0] expQ[$];
    logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
    int nFail = 0, checks = 0, nStart = 0, nArr = 0, nWid = 0;

    htp_top htp_top_i (.mclk(mclk), .rstn(rstn), .avReq(avReq),
        .avReaddata(avReaddata), .avWaitrequest(avWaitrequest),
        .hitIn(hitIn), .gatedClkIn(gatedClkIn), .start(start),
        .arrivalSampleClock(arrivalSampleClock),
        .widthSampleClock(widthSampleClock), .cfg(cfg), .words(words));
    htp_fe_model #(.FRAME(FRAME), .HI(HI), .LO(LO)) htp_fe_model_i (
        .mclk(mclk), .rstn(rstn), .armHit(armHit), .hitOfs(hitOfs),
        .hitLen(hitLen), .hitIn(hitIn), .gatedClkIn(gatedClkIn),
        .phase(phase));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Edge counters and read-data checker
    always @(posedge mclk) begin
        if (start === 1'b1 && pStart !== 1'b1) nStart++;
        if (arrivalSampleClock === 1'b1 && pArr !== 1'b1) nArr++;
        if (widthSampleClock === 1'b1 && pWid !== 1'b1) nWid++;
        pStart <= start;
        pArr <= arrivalSampleClock;
        pWid <= widthSampleClock;
        if (avReq.read === 1'b1 && avWaitrequest === 1'b0) begin
            if (expQ.size() == 0) begin
                nFail++;
                $display("ERROR t=%0t got=%h exp=none", $time, avReaddata);
            end else begin
                rdExp = expQ.pop_front();
                `CHK(avReaddata, rdExp)
            end
        end
    end

    task automatic bus(input logic isRd, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge mclk);
        avReq <= '{read: isRd, write: !isRd, address: a, writedata: d};
        do begin
            @(posedge mclk);
        end while (avWaitrequest !== 1'b0);
        avReq <= '0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b0, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expQ.push_back(e);
        bus(1'b1, a, 32'h0);
    endtask

    task automatic endt(input string s);
        $display("test %s done", s);
    endtask

    task automatic hit_frame(input logic arm, input logic [3:0] o,
        input logic [7:0] l, input int eS, input int eA, input int eW);
        int s0, a0, w0;
        do @(posedge mclk); while (phase !== 8'(FRAME - 2));
        armHit <= arm;
        hitOfs <= o;
        hitLen <= l;
        s0 = nStart;
        a0 = nArr;
        w0 = nWid;
        repeat (FRAME) @(posedge mclk);
        armHit <= 1'b0;
        `CHK(nStart - s0, eS)
        `CHK(nArr - a0, eA)
        `CHK(nWid - w0, eW)
        if (eS == 1) begin
            `CHK(words.calibration, 8'(HI + LO))
            rd(`HTP_OFS_ARRIVAL, 32'(o) + 32'h1);
            rd(`HTP_OFS_WIDTH, 32'(l) + 32'h1);
            rd(`HTP_OFS_CAL, 32'(HI + LO));
            rd(`HTP_OFS_STATUS, 32'h2);
            wr(`HTP_OFS_STATUS, 32'h6);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, nFail);
        if (nFail == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (12000) @(posedge mclk);
        nFail++;
        print_verdict();
    end

    initial begin
        rstn = 1'b0;
        avReq = '0;
        armHit = 1'b0;
        hitOfs = 4'h0;
        hitLen = 8'h00;
        seed = 32'hadd0;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        #1;
        `CHK(cfg, 15'h0)
        `CHK(start, 1'b0)
        rd(`HTP_OFS_CTRL, 32'h1);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            cfgExp = '{seed[9:0], 2'(i), codes[i]};
            wr(`HTP_OFS_CONFIG, {17'h0, codes[i], 2'(i), seed[9:0]});
            @(posedge mclk);
            #1;
            `CHK(cfg, cfgExp)
            rd(`HTP_OFS_CONFIG, {17'h0, codes[i], 2'(i), seed[9:0]});
        end
        wr(`HTP_OFS_CONFIG, {17'h0, 3'h2, 2'h1, 10'h155});
        cfgExp.threshold = 10'h155;
        cfgExp.hysteresis = 2'h1;
        @(posedge mclk);
        #1;
        `CHK(cfg, cfgExp)
        wr(8'h20, 32'hffffffff);
        rd(8'h20, 32'h0);
        endt("config");
        wr(`HTP_OFS_STATUS, 32'h6);
        hit_frame(1'b0, 4'h0, 8'h00, 0, 0, 0);
        rd(`HTP_OFS_STATUS, 32'h0);
        endt("quiet");
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            hit_frame(1'b1, 4'(i % 2), 8'h0c + 8'(seed[3:0]), 1, 2, 1);
        end
        endt("hits");
        hit_frame(1'b1, 4'h2, 8'h0e, 0, 0, 0);
        rd(`HTP_OFS_STATUS, 32'h4);
        wr(`HTP_OFS_STATUS, 32'h6);
        endt("window");
        wr(`HTP_OFS_CTRL, 32'h0);
        hit_frame(1'b1, 4'h0, 8'h0e, 0, 0, 0);
        rd(`HTP_OFS_STATUS, 32'h4);
        wr(`HTP_OFS_STATUS, 32'h6);
        wr(`HTP_OFS_CTRL, 32'h3);
        rd(`HTP_OFS_CTRL, 32'h1);
        hit_frame(1'b1, 4'h1, 8'h14, 1, 2, 1);
        wr(`HTP_OFS_CAL, 32'hff);
        rd(`HTP_OFS_CAL, 32'(HI + LO));
        endt("control");
        do @(posedge mclk); while (phase !== 8'h28);
        wr(`HTP_OFS_CTRL, 32'hd);
        repeat (8) @(posedge mclk);
        rd(`HTP_OFS_CTRL, 32'h5);
        rd(`HTP_OFS_STATUS, 32'h4);
        wr(`HTP_OFS_CTRL, 32'h1);
        wr(`HTP_OFS_STATUS, 32'h6);
        endt("test");
        print_verdict();
    end
endmodule
`default_nettype wire

// ---- tb/htp_fe_model.sv ----
// Stand-in for the comparator and the gated clock source
// Assumes it is clocked from mclk; one gated frame lasts FRAME cycles
`timescale 1ns/10ps
`default_nettype none
module htp_fe_model #(
    parameter int FRAME = 64,
    parameter int FIRST = 16,
    parameter int HI = 4,
    parameter int LO = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Hit request from the bench
    input wire logic armHit,
    input wire logic [3:0] hitOfs,
    input wire logic [7:0] hitLen,
    // Pins toward the block
    output var logic hitIn,
    output var logic gatedClkIn,
    output var logic [7:0] phase
);
    logic armed;
    logic [3:0] ofs;
    logic [7:0] len;
    wire logic signed [31:0] ph = int'(phase);
    wire logic signed [31:0] hitAt = FIRST - int'(ofs);
    // Two pulses per frame, idle low in between
    wire logic pulseNow = (ph >= FIRST && ph < FIRST + HI) ||
        (ph >= FIRST + HI + LO && ph < FIRST + 2 * HI + LO);
    // Hit placed relative to the first gated rise
    wire logic hitNow = armed && ph >= hitAt && ph < hitAt + int'(len);
    wire logic frameEnd = (ph == FRAME - 1);

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            phase <= 8'h00;
            armed <= 1'b0;
            ofs <= 4'h0;
            len <= 8'h00;
            hitIn <= 1'b0;
            gatedClkIn <= 1'b0;
        end else begin
            phase <= frameEnd ? 8'h00 : phase + 8'h01;
            if (frameEnd) begin
                armed <= armHit;
                ofs <= hitOfs;
                len <= hitLen;
            end
            gatedClkIn <= pulseNow;
            hitIn <= hitNow;
        end
    end
endmodule
`default_nettype wire
